// file: sacc_map.svh
// Constants for the successive-approximation converter control block
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH
// Conversion lengths in converter clock cycles
`define SACC_NORMAL_CYCLES 5'h0D
`define SACC_FIRST_CYCLES 5'h19
// Sample points, in half converter cycles from start
`define SACC_NORMAL_SAMPLE_HALF 6'h03
`define SACC_FIRST_SAMPLE_HALF 6'h1B
// Trigger source code for the converter's own completion flag
`define SACC_TRIG_FREE 3'h0
// Prescaler divide field and lowest ratio
`define SACC_PS_MIN_SHIFT 3'h1
`define SACC_PS_MAX_SHIFT 3'h7
// Six-bit zero fill for the result bytes
`define SACC_RES_ZERO 6'h00
`endif

// file: sacc_pkg.sv
// Types shared by the converter control block
package sacc_pkg;
  // Selection word copied into the converter
  typedef struct packed {
    logic [1:0] reference_select_field;
    logic [3:0] channel_select_field;
  } sacc_sel_t;
  // Conversion sequencer states, one bit changing from IDLE to WAIT and from WAIT to CONV
  typedef enum logic [1:0] {
    SACC_IDLE = 2'h0,
    SACC_WAIT = 2'h1,
    SACC_CONV = 2'h3
  } sacc_state_t;
endpackage : sacc_pkg

// file: sacc_prescaler.sv
// Converter clock prescaler producing edge pulses
`timescale 1ns/100ps
`include "sacc_map.svh"
module sacc_prescaler (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [2:0] prescaler_select,
  output logic rise,
  output logic fall
);
  // ==========================================
  // Free counter
  logic [6:0] count; // Divider count
  logic [2:0] shift; // Effective divide exponent
  logic [6:0] top; // Last count of a period
  logic [6:0] half; // Count where the clock falls
  always_comb begin
    // Codes zero and one both divide by two
    shift = (prescaler_select < `SACC_PS_MIN_SHIFT) ? `SACC_PS_MIN_SHIFT : prescaler_select;
    top = 7'((8'h01 << shift) - 8'h01);
    half = 7'(top >> 1);
  end
  // Held reset while disabled or on trigger
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run || restart) begin
      count <= 7'h00;
    end else if (count >= top) begin
      // A smaller divide chosen mid-count wraps at once
      count <= 7'h00;
    end else begin
      count <= 7'(count + 7'h01);
    end
  end
  // Edge pulses of the derived clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run || restart) begin
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= (count == top);
      fall <= (count == half);
    end
  end
endmodule : sacc_prescaler

// file: sacc_sync3.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module sacc_sync3 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // ==========================================
  // Synchroniser chain
  logic s1; // First stage, read only by s2
  logic s2; // Second stage
  logic s3; // Third stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Output changes once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule : sacc_sync3

// file: sacc_control.sv
// Conversion control of a ten-bit successive-approximation converter
`timescale 1ns/100ps
`include "sacc_map.svh"
module sacc_control (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic converter_power_reduction,
  input wire logic converter_enable,
  input wire logic start_conversion_write,
  input wire logic auto_trigger_enable,
  input wire logic [2:0] trigger_source_select,
  input wire logic [7:0] trigger_sources,
  input wire logic [2:0] prescaler_select,
  input wire logic left_adjust_result,
  input wire logic [3:0] channel_select_field,
  input wire logic [1:0] reference_select_field,
  input wire logic conversion_complete_irq_enable,
  input wire logic conversion_complete_flag_clear,
  input wire logic result_low_read,
  input wire logic result_high_read,
  input wire logic [9:0] analog_code,
  output logic start_conversion_bit,
  output logic conversion_complete_flag,
  output logic conversion_complete_irq,
  output logic [7:0] result_high_byte,
  output logic [7:0] result_low_byte,
  output logic [3:0] converter_channel,
  output logic [1:0] converter_reference,
  output logic analog_enable,
  output logic analog_sample,
  output logic analog_convert_done
);
  // ==========================================
  // Enable gating and prescaler
  logic active; // Converter powered and enabled
  logic ck_rise; // Converter clock rising edge pulse
  logic ck_fall; // Converter clock falling edge pulse
  logic trig_sync; // Synchronised external trigger level
  logic trig_prev; // Previous trigger level
  logic trig_edge; // Fresh rising trigger edge
  logic auto_mode; // Auto trigger active
  logic free_mode; // Own flag selected as trigger
  logic trig_hit; // Accepted trigger start
  sacc_pkg::sacc_state_t state; // Sequencer state
  sacc_pkg::sacc_sel_t sel_live; // Converter side selection
  logic [4:0] cyc; // Converter cycles elapsed
  logic [5:0] half_cnt; // Half cycles since start
  logic first_pending; // Next conversion is the first
  logic is_first; // Running conversion is the first
  logic from_trigger; // Running conversion auto triggered
  logic [4:0] conv_len; // Length of running conversion
  logic [5:0] samp_half; // Sample point of running conversion
  logic last_cycle; // Final converter cycle of a conversion
  logic finish; // Completion this clock
  logic locked; // Result bytes blocked
  logic sw_pending; // Software start waiting for clock edge
  logic [4:0] done_cyc; // Rise count at which the conversion ends
  logic done_edge; // Converter edge that ends the conversion

  // ==========================================
  // State decodes used by several processes
  function automatic logic sacc_is_idle(input sacc_pkg::sacc_state_t st);
    return (st == sacc_pkg::SACC_IDLE);
  endfunction : sacc_is_idle
  function automatic logic sacc_is_conv(input sacc_pkg::sacc_state_t st);
    return (st == sacc_pkg::SACC_CONV);
  endfunction : sacc_is_conv

  // Power reduction overrides the enable
  assign active = converter_enable && !converter_power_reduction;
  assign auto_mode = active && auto_trigger_enable;
  // Own completion flag as trigger means free running
  assign free_mode = auto_mode && (trigger_source_select == `SACC_TRIG_FREE);

  // Derived converter clock, restarted by accepted triggers
  sacc_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(active),
    .restart(trig_hit),
    .prescaler_select(prescaler_select),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  // Selected trigger level through four flip-flops
  sacc_sync3 u_trig_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(trigger_sources[trigger_source_select]),
    .dout(trig_sync)
  );

  // ==========================================
  // Trigger edge detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_sync;
    end
  end
  // Edge only counts when idle; level alone never starts
  assign trig_edge = trig_sync && !trig_prev;
  // A software start in the same cycle takes precedence
  assign trig_hit = auto_mode && !free_mode && trig_edge && !start_conversion_write
                    && sacc_is_idle(state);

  // ==========================================
  // Conversion timing figures
  always_comb begin
    conv_len = is_first ? `SACC_FIRST_CYCLES : `SACC_NORMAL_CYCLES;
    samp_half = is_first ? `SACC_FIRST_SAMPLE_HALF : `SACC_NORMAL_SAMPLE_HALF;
  end
  // Triggered conversions end half a cycle later, on a falling edge
  assign done_cyc = from_trigger ? conv_len : 5'(conv_len - 5'h01);
  assign done_edge = from_trigger ? ck_fall : ck_rise;
  // Final converter cycle, where selection copying resumes
  assign last_cycle = sacc_is_conv(state)
                      && (cyc == 5'(conv_len - 5'h01) || cyc == done_cyc);
  assign finish = sacc_is_conv(state) && (cyc == done_cyc) && done_edge;

  // ==========================================
  // Software start request
  // Marks a start that waits for the next converter edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active) begin
      sw_pending <= 1'b0;
    end else if (start_conversion_write && sacc_is_idle(state)) begin
      sw_pending <= 1'b1;
    end else if (state == sacc_pkg::SACC_WAIT && ck_rise) begin
      sw_pending <= 1'b0;
    end
  end

  // ==========================================
  // Sequencer
  // Idle, waiting for a converter edge, or converting
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active) begin
      state <= sacc_pkg::SACC_IDLE;
    end else begin
      unique case (state)
        sacc_pkg::SACC_IDLE: begin
          if (start_conversion_write) begin
            state <= sacc_pkg::SACC_WAIT;
          end else if (trig_hit) begin
            state <= sacc_pkg::SACC_CONV;
          end
        end
        sacc_pkg::SACC_WAIT: begin
          if (ck_rise) begin
            state <= sacc_pkg::SACC_CONV;
          end
        end
        sacc_pkg::SACC_CONV: begin
          if (finish && !free_mode) begin
            state <= sacc_pkg::SACC_IDLE;
          end
        end
        default: begin
          state <= sacc_pkg::SACC_IDLE;
        end
      endcase
    end
  end

  // Cycle and half-cycle counters of a conversion
  // Cleared between conversions and at every completion
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sacc_is_conv(state) || finish) begin
      cyc <= 5'h00;
      half_cnt <= `SACC_RES_ZERO;
    end else begin
      if (ck_rise) begin
        cyc <= 5'(cyc + 5'h01);
      end
      if (ck_rise || ck_fall) begin
        half_cnt <= 6'(half_cnt + 6'h01);
      end
    end
  end

  // First conversion after enable is long
  // Also records whether the running conversion was triggered
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active) begin
      first_pending <= 1'b1;
      is_first <= 1'b0;
      from_trigger <= 1'b0;
    end else if ((sw_pending && ck_rise) || trig_hit) begin
      is_first <= first_pending;
      first_pending <= 1'b0;
      from_trigger <= trig_hit;
    end else if (finish) begin
      is_first <= 1'b0;
      from_trigger <= 1'b0;
    end
  end

  // ==========================================
  // Start bit: high through any conversion
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      start_conversion_bit <= 1'b0;
    end else if (!active) begin
      start_conversion_bit <= 1'b0;
    end else if (finish && !free_mode) begin
      start_conversion_bit <= 1'b0;
    end else if (start_conversion_write || trig_hit) begin
      start_conversion_bit <= 1'b1;
    end
  end

  // ==========================================
  // Selection buffering into the converter
  // A disabled converter keeps its last selection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_live <= '0;
    end else if (active && (!sacc_is_conv(state) || last_cycle)) begin
      // Updates until conversion starts, resume in last cycle
      sel_live.channel_select_field <= channel_select_field;
      sel_live.reference_select_field <= reference_select_field;
    end
  end
  // Drive converter selection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      converter_channel <= 4'h0;
      converter_reference <= 2'h0;
    end else begin
      converter_channel <= sel_live.channel_select_field;
      converter_reference <= sel_live.reference_select_field;
    end
  end

  // ==========================================
  // Analog front end handshake
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_enable <= 1'b0;
      analog_sample <= 1'b0;
      analog_convert_done <= 1'b0;
    end else begin
      analog_enable <= active;
      // Pulse on the converter edge at the sample point
      // Triggered sampling lands half a cycle later
      analog_sample <= sacc_is_conv(state) && (ck_rise || ck_fall)
                       && (half_cnt == 6'(samp_half - (from_trigger ? 6'h00 : 6'h01)));
      analog_convert_done <= finish;
    end
  end

  // ==========================================
  // Result lock
  // Low byte read blocks updates until the high byte is read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (result_high_read) begin
      locked <= 1'b0;
    end else if (result_low_read) begin
      locked <= 1'b1;
    end
  end

  // Result bytes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (finish && !locked) begin
      if (left_adjust_result) begin
        result_high_byte <= analog_code[9:2];
        result_low_byte <= {analog_code[1:0], `SACC_RES_ZERO};
      end else begin
        result_high_byte <= {`SACC_RES_ZERO, analog_code[9:8]};
        result_low_byte <= analog_code[7:0];
      end
    end
  end

  // ==========================================
  // Completion flag; set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conversion_complete_flag <= 1'b0;
    end else if (finish) begin
      conversion_complete_flag <= 1'b1;
    end else if (conversion_complete_flag_clear) begin
      conversion_complete_flag <= 1'b0;
    end
  end
  // Interrupt request
  // Follows the flag's next value so it rises with the flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conversion_complete_irq <= 1'b0;
    end else begin
      conversion_complete_irq <= (conversion_complete_flag || finish)
                                 && conversion_complete_irq_enable
                                 && !(conversion_complete_flag_clear && !finish);
    end
  end
endmodule : sacc_control

// file: sacc_control_monitor.sv
// Port-level checker for the converter control block
`timescale 1ns/100ps
module sacc_control_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic converter_power_reduction,
  input wire logic converter_enable,
  input wire logic start_conversion_write,
  input wire logic conversion_complete_irq_enable,
  input wire logic conversion_complete_flag_clear,
  input wire logic start_conversion_bit,
  input wire logic conversion_complete_flag,
  input wire logic conversion_complete_irq,
  input wire logic [3:0] converter_channel,
  input wire logic [1:0] converter_reference,
  input wire logic analog_enable,
  input wire logic analog_sample
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Power, start and completion
  property p_off;
    converter_power_reduction [*3] |-> !analog_enable && !analog_sample;
  endproperty
  a_off: assert property (p_off) else $error("analog active while powered down");
  property p_nostart;
    converter_power_reduction && $past(converter_power_reduction) |-> !$rose(start_conversion_bit);
  endproperty
  a_nostart: assert property (p_nostart) else $error("start while powered down");
  property p_go;
    start_conversion_write && converter_enable && !converter_power_reduction
      && !start_conversion_bit |=> start_conversion_bit;
  endproperty
  a_go: assert property (p_go) else $error("start bit not set by write");
  property p_done;
    $fell(start_conversion_bit) && $past(converter_enable) |-> conversion_complete_flag;
  endproperty
  a_done: assert property (p_done) else $error("start bit cleared without flag");
  property p_hold;
    conversion_complete_flag && !conversion_complete_flag_clear && converter_enable
      |=> conversion_complete_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost without clear");
  property p_irq;
    $rose(conversion_complete_flag) && conversion_complete_irq_enable
      |-> ##[0:1] conversion_complete_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq on completion");
  // ==========================================
  // Selection copying
  property p_lock;
    analog_sample |-> start_conversion_bit && $stable(converter_channel)
      && $stable(converter_reference);
  endproperty
  a_lock: assert property (p_lock) else $error("selection moved during conversion");
  property p_idle;
    !converter_enable [*2] |=> $stable(converter_channel) && $stable(converter_reference);
  endproperty
  a_idle: assert property (p_idle) else $error("selection moved while disabled");
endmodule : sacc_control_monitor
bind sacc_control sacc_control_monitor u_mon (.*);

// file: sacc_analog_model.sv
// Behavioural analog front end: sample-and-hold and code source
`timescale 1ns/100ps
module sacc_analog_model (
  input wire logic clk_sys,
  input wire logic analog_enable,
  input wire logic analog_sample,
  input wire logic analog_convert_done,
  input wire logic [3:0] converter_channel,
  input wire logic [1:0] converter_reference,
  output logic [9:0] analog_code
);
  logic [9:0] held = 10'h000; // Code caught at sample time
  logic valid = 1'b0; // Code held until conversion ends
  initial analog_code = 10'h2A5;
  // Catch selection at the sample pulse, drop at end or disable
  always @(posedge clk_sys) begin
    if (analog_enable && analog_sample) begin
      held <= {converter_reference, converter_channel, 4'hA};
      valid <= 1'b1;
    end else if (analog_convert_done || !analog_enable) begin
      valid <= 1'b0;
    end
  end
  // Outside the hold window the code toggles every cycle
  always @(negedge clk_sys) analog_code <= valid ? held : ~analog_code;
endmodule : sacc_analog_model

// file: sacc_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module sacc_control_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic converter_power_reduction = 1'b1;
  logic converter_enable = 1'b0;
  logic start_conversion_write = 1'b0;
  logic auto_trigger_enable = 1'b0;
  logic [2:0] trigger_source_select = 3'h0;
  logic [7:0] trigger_sources = 8'h00;
  logic [2:0] prescaler_select = 3'h0; // Divide by two
  logic left_adjust_result = 1'b0;
  logic [3:0] channel_select_field = 4'h0;
  logic [1:0] reference_select_field = 2'h0;
  logic conversion_complete_irq_enable = 1'b0;
  logic conversion_complete_flag_clear = 1'b0;
  logic result_low_read = 1'b0;
  logic result_high_read = 1'b0;
  logic [9:0] analog_code;
  logic start_conversion_bit, conversion_complete_flag, conversion_complete_irq;
  logic [7:0] result_high_byte, result_low_byte;
  logic [3:0] converter_channel;
  logic [1:0] converter_reference;
  logic analog_enable, analog_sample, analog_convert_done;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  sacc_control dut (.*);
  sacc_analog_model u_afe (.*);
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================
  // Shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task automatic wait_flag(input int lim, inout int n);
    while (conversion_complete_flag !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_flag
  // Single conversion, selection changed four cycles in
  task automatic conv(input int lo, input int hi, input logic [9:0] c, input logic [5:0] nsel);
    int n;
    logic [3:0] oldch;
    n = 4;
    oldch = channel_select_field;
    pulse(start_conversion_write);
    tick(4);
    {reference_select_field, channel_select_field} = nsel;
    check(16'(converter_channel), 16'(oldch));
    wait_flag(200, n);
    check(16'(n >= lo && n <= hi), 16'h1);
    check({result_high_byte, result_low_byte}, left_adjust_result ? {c, 6'h00} : 16'(c));
    check(16'(start_conversion_bit), 16'h0);
    tick(1);
    check(16'(conversion_complete_irq), 16'(conversion_complete_irq_enable));
    check(16'(converter_channel), 16'(nsel[3:0]));
    check(16'(converter_reference), 16'(nsel[5:4]));
    pulse(conversion_complete_flag_clear);
    tick(2);
  endtask : conv
  // ==========================================
  // Scenarios
  task automatic t_power_and_first;
    converter_enable = 1'b1;
    pulse(start_conversion_write);
    tick(60);
    check(16'({start_conversion_bit, conversion_complete_flag}), 16'h0);
    converter_enable = 1'b0;
    converter_power_reduction = 1'b0;
    {reference_select_field, channel_select_field} = 6'h15;
    tick(4);
    check(16'(converter_channel), 16'h0);
    converter_enable = 1'b1;
    tick(4);
    check(16'(converter_channel), 16'h5);
    conv(50, 54, 10'h15A, 6'h15);
  endtask : t_power_and_first
  task automatic t_left_and_lock;
    left_adjust_result = 1'b1;
    conv(26, 30, 10'h15A, 6'h29);
    conversion_complete_irq_enable = 1'b1;
    pulse(result_low_read);
    conv(26, 30, 10'h15A, 6'h29);
    prescaler_select = 3'h2;
    pulse(result_high_read);
    conv(52, 58, 10'h29A, 6'h33);
    prescaler_select = 3'h0;
  endtask : t_left_and_lock
  task automatic t_trigger;
    int n;
    n = 0;
    auto_trigger_enable = 1'b1;
    trigger_source_select = 3'h3;
    trigger_sources[3] = 1'b1;
    wait_flag(45, n);
    check(16'(conversion_complete_flag), 16'h1);
    pulse(conversion_complete_flag_clear);
    tick(80);
    check(16'({start_conversion_bit, conversion_complete_flag}), 16'h0);
    trigger_sources[3] = 1'b0;
    tick(3);
    trigger_sources[3] = 1'b1;
    tick(12);
    trigger_sources[3] = 1'b0;
    tick(3);
    trigger_sources[3] = 1'b1;
    n = 18;
    wait_flag(45, n);
    check(16'(conversion_complete_flag), 16'h1);
    pulse(conversion_complete_flag_clear);
    tick(60);
    check(16'(conversion_complete_flag), 16'h0);
  endtask : t_trigger
  task automatic t_free;
    int k;
    k = 0;
    trigger_source_select = 3'h0;
    pulse(start_conversion_write);
    repeat (150) begin
      tick(1);
      k += analog_convert_done;
      if (start_conversion_bit !== 1'b1) begin
        check(16'(start_conversion_bit), 16'h1);
      end
    end
    check(16'(k >= 4), 16'h1);
    converter_enable = 1'b0;
    tick(3);
    check(16'(start_conversion_bit), 16'h0);
  endtask : t_free
  // ==========================================
  // Verdict and run control
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(2);
    t_power_and_first();
    t_left_and_lock();
    t_trigger();
    t_free();
    finish_test();
  end
endmodule : sacc_control_tb
